// ---- dv/dlr_host.sv ----
/*
  Holds: host model issuing register writes and reads on the strobe port.
  Assumes: same clock as the slice; calls begin after the load edge.
*/
`timescale 1ns/1ps
module dlr_host (
  // Clock
  input logic clock,
  // Register port
  output logic [4:0] reg_addr = 5'h00,
  output logic [15:0] reg_wdata = 16'h0000,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  input logic [15:0] reg_rdata_r,
  input logic reg_rvalid_r
);
  task wr(input logic [4:0] a, input logic [15:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
      @(posedge clock);
    end
  endtask
  task rd(input logic [4:0] a, output logic [15:0] d);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(posedge clock);
      d = reg_rvalid_r ? reg_rdata_r : 16'hxxxx;
    end
  endtask
endmodule

// ---- dv/dlr_props.sv ----
/*
  Holds: port assertions for the lock and reference selection slice.
  Assumes: bound to dlr_lock_ref; one clock, nrst active low.
*/
`timescale 1ns/1ps
`include "dlr_map.vh"
module dlr_props (
  // Clock and reset
  input logic clock,
  input logic nrst,
  // Register port
  input logic [4:0] reg_addr,
  input logic [15:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  input logic [15:0] reg_rdata_r,
  input logic reg_rvalid_r,
  input logic reg_wr_ignored_r,
  // Ladder and routing
  input logic [11:0] ch0_tap,
  input logic [1:0] ladder_connect,
  input logic [1:0] ref_vdd_sel_r,
  input logic [1:0] ref_bandgap_sel_r,
  input logic [1:0] ref_pin_unbuf_sel_r,
  input logic [1:0] ref_pin_buf_sel_r,
  input logic [1:0] vref_pin_connect_r,
  input logic [1:0] ref_buffer_gain2_r,
  input logic [1:0] output_gain2_r
);
  wire [1:0] any_sel = ref_vdd_sel_r | ref_bandgap_sel_r | ref_pin_unbuf_sel_r | ref_pin_buf_sel_r;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence s_lock_rd;
    reg_rd && reg_addr == `DLR_OFS_LOCK;
  endsequence
  sequence s_pd_wr;
    reg_wr && reg_addr == `DLR_OFS_PDOWN && reg_wdata[1:0] != 2'h0;
  endsequence
  a_lock_read_zero: assert property (s_lock_rd |=> reg_rvalid_r && reg_rdata_r[15:4] == 12'h000)
    else $error("lock read upper bits not zero");
  a_pdown_opens: assert property (s_pd_wr |-> ##2 !ladder_connect[0])
    else $error("power-down left ladder connected");
  a_pdown_switch_off: assert property ((~ladder_connect & (any_sel | vref_pin_connect_r)) == 2'h0)
    else $error("switch closed in power-down");
  a_vdd_no_pin: assert property ((ref_vdd_sel_r & vref_pin_connect_r) == 2'h0)
    else $error("pin joined while supply selected");
  a_pin_routes: assert property (vref_pin_connect_r == (ref_pin_unbuf_sel_r | ref_pin_buf_sel_r))
    else $error("pin connect disagrees with select");
  a_bandgap_gain2: assert property (ref_buffer_gain2_r == ref_bandgap_sel_r)
    else $error("band gap buffer gain wrong");
  a_vdd_unity_gain: assert property ((ref_vdd_sel_r & output_gain2_r) == 2'h0)
    else $error("gain 2 with supply reference");
  a_ref_one_hot: assert property ($onehot0({ref_vdd_sel_r[0], ref_bandgap_sel_r[0], ref_pin_unbuf_sel_r[0], ref_pin_buf_sel_r[0]}) && $onehot0({ref_vdd_sel_r[1], ref_bandgap_sel_r[1], ref_pin_unbuf_sel_r[1], ref_pin_buf_sel_r[1]}))
    else $error("more than one reference selected");
  a_tap_cause: assert property ($changed(ch0_tap) |-> $past(reg_wr, 2) && $past(reg_addr, 2) == `DLR_OFS_VALUE0)
    else $error("tap moved without value write");
  a_ignored_cause: assert property (reg_wr_ignored_r |-> $past(reg_wr) || $past(reg_wr, 2))
    else $error("ignored flag without write");
endmodule
bind dlr_lock_ref dlr_props dlr_props_i (.*);

// ---- dv/tb.sv ----
/*
  Holds: self-checking bench for the lock and reference slice.
  Assumes: dlr_host drives the register port; bench drives storage levels.
*/
`timescale 1ns/1ps
`include "dlr_map.vh"
module tb;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic nv_present = 1'b1;
  logic [3:0] nv_reference_select = 4'h9;
  logic [3:0] nv_channel_lock = 4'h0;
  wire [4:0] reg_addr;
  wire [15:0] reg_wdata, reg_rdata_r;
  wire reg_wr, reg_rd, reg_rvalid_r, reg_wr_ignored_r;
  wire [11:0] ch0_tap, ch1_tap;
  wire [1:0] ladder_connect, ref_vdd_sel_r, ref_bandgap_sel_r, ref_pin_unbuf_sel_r;
  wire [1:0] ref_pin_buf_sel_r, vref_pin_connect_r, ref_buffer_gain2_r, output_gain2_r;
  int n_fail = 0;
  int checks_done = 0;
  int n_ign = 0;
  logic [15:0] d;
  logic [11:0] ev;
  logic [1:0] er;
  always #25 clock = ~clock;
  // Counts the one-cycle refused-write pulses
  always @(posedge clock) begin
    if (reg_wr_ignored_r) n_ign <= n_ign + 1;
  end
  dlr_lock_ref dlr_lock_ref_i (.*);
  dlr_host dlr_host_i (.*);
  ////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task do_reset(input logic p, input logic [3:0] sel, input logic [3:0] lk);
    @(posedge clock);
    nrst <= 1'b0;
    nv_present <= p;
    nv_reference_select <= sel;
    nv_channel_lock <= lk;
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    repeat (2) @(posedge clock);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset(1'b1, 4'h9, 4'h0);
    dlr_host_i.rd(`DLR_OFS_VREF, d);
    chk("vref load", d, 16'h0009);
    chk("bandgap route", ref_bandgap_sel_r, 2'b01);
    chk("pin route", ref_pin_unbuf_sel_r, 2'b10);
    dlr_host_i.rd(`DLR_OFS_LOCK, d);
    chk("lock reset", d, 16'h0000);
    $display("test load done");
    dlr_host_i.wr(`DLR_OFS_VALUE0, 16'hffff);
    dlr_host_i.wr(`DLR_OFS_VALUE1, 16'h0800);
    #1;
    chk("tap0", ch0_tap, 12'hfff);
    chk("tap1", ch1_tap, 12'h800);
    dlr_host_i.rd(`DLR_OFS_VALUE0, d);
    chk("value0", d, 16'h0fff);
    $display("test taps done");
    dlr_host_i.wr(`DLR_OFS_GAIN, 16'h0300);
    for (int m = 0; m < 4; m++) begin
      // Pin codes stand for an external source on the pin
      dlr_host_i.wr(`DLR_OFS_VREF, {12'h000, m[1:0], m[1:0]});
      #1;
      chk("vdd", ref_vdd_sel_r, {2{m == 0}});
      chk("bandgap", ref_buffer_gain2_r, {2{m == 1}});
      chk("pin", vref_pin_connect_r, {2{m[1]}});
      chk("buffered", ref_pin_buf_sel_r, {2{m == 3}});
      chk("gain", output_gain2_r, {2{m != 0}});
    end
    $display("test reference done");
    ev = 12'hfff;
    er = 2'h3;
    for (int k = 0; k < 4; k++) begin
      dlr_host_i.wr(`DLR_OFS_LOCK, {12'hfff, 2'h0, k[1:0]});
      dlr_host_i.wr(`DLR_OFS_VALUE0, {4'h0, 10'h040, k[1:0]});
      dlr_host_i.wr(`DLR_OFS_VREF, {14'h0000, k[1:0] + 2'h1});
      if (!k[1]) ev = {10'h040, k[1:0]};
      if (!k[0]) er = k[1:0] + 2'h1;
      dlr_host_i.rd(`DLR_OFS_LOCK, d);
      chk("lock", d, {14'h0000, k[1:0]});
      dlr_host_i.rd(`DLR_OFS_VALUE0, d);
      chk("locked value", d, {4'h0, ev});
      dlr_host_i.rd(`DLR_OFS_VREF, d);
      chk("locked vref", d, {14'h0000, er});
    end
    chk("ignored count", n_ign[15:0], 16'h0004);
    $display("test lock done");
    dlr_host_i.wr(`DLR_OFS_LOCK, 16'h000f);
    dlr_host_i.wr(`DLR_OFS_PDOWN, 16'h0009);
    #1;
    chk("pd open", ladder_connect, 2'b00);
    chk("pd sw", ref_vdd_sel_r | ref_bandgap_sel_r | ref_pin_unbuf_sel_r, 2'b00);
    dlr_host_i.wr(`DLR_OFS_PDOWN, 16'h0000);
    #1;
    chk("pd exit", ladder_connect, 2'b11);
    dlr_host_i.rd(5'h1f, d);
    chk("unmapped", d, 16'h0000);
    $display("test powerdown done");
    do_reset(1'b0, 4'hf, 4'hf);
    dlr_host_i.rd(`DLR_OFS_VREF, d);
    chk("vref default", d, 16'h0000);
    chk("vdd default", ref_vdd_sel_r, 2'b11);
    dlr_host_i.rd(`DLR_OFS_LOCK, d);
    chk("lock default", d, 16'h0000);
    $display("test defaults done");
    do_reset(1'b1, 4'h6, 4'ha);
    dlr_host_i.rd(`DLR_OFS_LOCK, d);
    chk("lock load", d, 16'h000a);
    dlr_host_i.wr(`DLR_OFS_VALUE1, 16'h0123);
    dlr_host_i.rd(`DLR_OFS_VALUE1, d);
    chk("stored lock value", d, 16'h0000);
    $display("test stored lock done");
    close_out;
  end
  initial begin
    repeat (5000) @(posedge clock);
    n_fail++;
    close_out;
  end
endmodule

// ---- src/dlr_lock_ref.v ----
/*
  Holds: top of the DAC lock and reference selection slice: register file
  with lock checks, reference routing and per-channel tap decoders.
  Assumes: a serial front end on the same clock presents one-cycle write and
  read strobes; nonvolatile contents arrive as levels on the same clock.
*/
`timescale 1ns/1ps
`include "dlr_map.vh"

module dlr_lock_ref (
  // Clock and reset
  input wire clock,
  input wire nrst,
  // Register access from the serial front end
  input wire [`DLR_ADDR_BITS-1:0] reg_addr,
  input wire [`DLR_DATA_BITS-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [`DLR_DATA_BITS-1:0] reg_rdata_r,
  output reg reg_rvalid_r,
  output reg reg_wr_ignored_r,
  // Nonvolatile contents
  input wire nv_present,
  input wire [2*`DLR_CHANNELS-1:0] nv_reference_select,
  input wire [2*`DLR_CHANNELS-1:0] nv_channel_lock,
  // Ladder taps and switches
  output wire [`DLR_RES_BITS-1:0] ch0_tap,
  output wire [`DLR_RES_BITS-1:0] ch1_tap,
  output wire [`DLR_CHANNELS-1:0] ladder_connect,
  // Reference routing per channel
  output reg [`DLR_CHANNELS-1:0] ref_vdd_sel_r,
  output reg [`DLR_CHANNELS-1:0] ref_bandgap_sel_r,
  output reg [`DLR_CHANNELS-1:0] ref_pin_unbuf_sel_r,
  output reg [`DLR_CHANNELS-1:0] ref_pin_buf_sel_r,
  output reg [`DLR_CHANNELS-1:0] vref_pin_connect_r,
  output reg [`DLR_CHANNELS-1:0] ref_buffer_gain2_r,
  output reg [`DLR_CHANNELS-1:0] output_gain2_r
);

  localparam NCH = `DLR_CHANNELS;

  // Power-up load sequencer
  localparam ST_LOAD = 1'b0;
  localparam ST_RUN = 1'b1;

  reg state_r;
  reg state_nxt;

  // Volatile and nonvolatile registers
  reg [`DLR_RES_BITS-1:0] value0_r;
  reg [`DLR_RES_BITS-1:0] value0_nxt;
  reg [`DLR_RES_BITS-1:0] value1_r;
  reg [`DLR_RES_BITS-1:0] value1_nxt;
  reg [2*NCH-1:0] reference_select_r;
  reg [2*NCH-1:0] reference_select_nxt;
  reg [2*NCH-1:0] powerdown_select_r;
  reg [2*NCH-1:0] powerdown_select_nxt;
  reg [NCH-1:0] output_gain_bit_r;
  reg [NCH-1:0] output_gain_bit_nxt;
  reg [2*NCH-1:0] channel_write_lock_r;
  reg [2*NCH-1:0] channel_write_lock_nxt;

  // Read path and write reporting
  reg [`DLR_DATA_BITS-1:0] reg_rdata_nxt;
  reg reg_wr_ignored_nxt;

  // Per-channel lock views and merged config fields
  wire [NCH-1:0] value_lock;
  wire [NCH-1:0] config_lock;
  wire [2*NCH-1:0] vref_wr_merged;
  wire [NCH-1:0] gain_wr_merged;
  wire [NCH-1:0] vref_wr_blocked;
  wire [NCH-1:0] gain_wr_blocked;
  wire [NCH*`DLR_RES_BITS-1:0] tap_all;

  // Routing next values
  reg [NCH-1:0] ref_vdd_sel_nxt;
  reg [NCH-1:0] ref_bandgap_sel_nxt;
  reg [NCH-1:0] ref_pin_unbuf_sel_nxt;
  reg [NCH-1:0] ref_pin_buf_sel_nxt;
  reg [NCH-1:0] vref_pin_connect_nxt;
  reg [NCH-1:0] ref_buffer_gain2_nxt;
  reg [NCH-1:0] output_gain2_nxt;

  wire wr_value0;
  wire wr_value1;
  wire wr_vref;
  wire wr_pdown;
  wire wr_gain;
  wire wr_lock;

  integer i;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode; strobes are held off during the power-up load
  assign wr_value0 = reg_wr && (state_r == ST_RUN) && (reg_addr == `DLR_OFS_VALUE0);
  assign wr_value1 = reg_wr && (state_r == ST_RUN) && (reg_addr == `DLR_OFS_VALUE1);
  assign wr_vref = reg_wr && (state_r == ST_RUN) && (reg_addr == `DLR_OFS_VREF);
  assign wr_pdown = reg_wr && (state_r == ST_RUN) && (reg_addr == `DLR_OFS_PDOWN);
  assign wr_gain = reg_wr && (state_r == ST_RUN) && (reg_addr == `DLR_OFS_GAIN);
  assign wr_lock = reg_wr && (state_r == ST_RUN) && (reg_addr == `DLR_OFS_LOCK);

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel lock split, field merge and tap decoders
  genvar c;
  generate
    for (c = 0; c < NCH; c = c + 1) begin : g_ch
      assign value_lock[c] = channel_write_lock_r[2*c+`DLR_LOCK_VAL_BIT];
      assign config_lock[c] = channel_write_lock_r[2*c+`DLR_LOCK_CFG_BIT];
      // Locked channel keeps its config field, others take the write
      assign vref_wr_merged[2*c+1:2*c] = config_lock[c] ?
        reference_select_r[2*c+1:2*c] : reg_wdata[2*c+1:2*c];
      assign gain_wr_merged[c] = config_lock[c] ?
        output_gain_bit_r[c] : reg_wdata[`DLR_GAIN_LSB+c];
      assign vref_wr_blocked[c] = config_lock[c] &&
        (reg_wdata[2*c+1:2*c] != reference_select_r[2*c+1:2*c]);
      assign gain_wr_blocked[c] = config_lock[c] &&
        (reg_wdata[`DLR_GAIN_LSB+c] != output_gain_bit_r[c]);
      dlr_tap_decode u_tap (
        .clock(clock),
        .nrst(nrst),
        .value((c == 0) ? value0_r : value1_r),
        .powerdown_select(powerdown_select_r[2*c+1:2*c]),
        .tap_r(tap_all[c*`DLR_RES_BITS +: `DLR_RES_BITS]),
        .connect_r(ladder_connect[c])
      );
    end
  endgenerate

  // Tap flops of each decoder drive the channel tap outputs
  assign ch0_tap = tap_all[`DLR_RES_BITS-1:0];
  assign ch1_tap = tap_all[2*`DLR_RES_BITS-1:`DLR_RES_BITS];

  ////////////////////////////////////////////////////////////////////////////
  // Register file next state
  always @* begin
    state_nxt = ST_RUN;
    value0_nxt = value0_r;
    value1_nxt = value1_r;
    reference_select_nxt = reference_select_r;
    powerdown_select_nxt = powerdown_select_r;
    output_gain_bit_nxt = output_gain_bit_r;
    channel_write_lock_nxt = channel_write_lock_r;
    reg_wr_ignored_nxt = 1'b0;
    case (state_r)
      ST_LOAD: begin
        // First edge after reset release copies the stored settings, or loads the reset values when nv_present is low
        if (nv_present) begin
          reference_select_nxt = nv_reference_select;
          channel_write_lock_nxt = nv_channel_lock;
        end else begin
          reference_select_nxt = `DLR_RST_VREF;
          channel_write_lock_nxt = `DLR_RST_LOCK;
        end
      end
      ST_RUN: begin
        if (wr_value0) begin
          if (value_lock[0]) begin
            reg_wr_ignored_nxt = 1'b1;
          end else begin
            value0_nxt = reg_wdata[`DLR_RES_BITS-1:0];
          end
        end
        if (wr_value1) begin
          if (value_lock[1]) begin
            reg_wr_ignored_nxt = 1'b1;
          end else begin
            value1_nxt = reg_wdata[`DLR_RES_BITS-1:0];
          end
        end
        if (wr_vref) begin
          reference_select_nxt = vref_wr_merged;
          reg_wr_ignored_nxt = |vref_wr_blocked;
        end
        if (wr_pdown) begin
          // Power-down always writable so a locked channel can wake
          powerdown_select_nxt = reg_wdata[2*NCH-1:0];
        end
        if (wr_gain) begin
          output_gain_bit_nxt = gain_wr_merged;
          reg_wr_ignored_nxt = |gain_wr_blocked;
        end
        if (wr_lock) begin
          channel_write_lock_nxt = reg_wdata[2*NCH-1:0];
        end
      end
      default: begin
        state_nxt = ST_LOAD;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped and unused bits read zero
  always @* begin
    reg_rdata_nxt = `DLR_RST_DATA;
    case (reg_addr)
      `DLR_OFS_VALUE0: reg_rdata_nxt[`DLR_RES_BITS-1:0] = value0_r;
      `DLR_OFS_VALUE1: reg_rdata_nxt[`DLR_RES_BITS-1:0] = value1_r;
      `DLR_OFS_VREF: reg_rdata_nxt[2*NCH-1:0] = reference_select_r;
      `DLR_OFS_PDOWN: reg_rdata_nxt[2*NCH-1:0] = powerdown_select_r;
      `DLR_OFS_GAIN: reg_rdata_nxt[`DLR_GAIN_LSB+NCH-1:`DLR_GAIN_LSB] = output_gain_bit_r;
      `DLR_OFS_LOCK: reg_rdata_nxt[2*NCH-1:0] = channel_write_lock_r;
      default: reg_rdata_nxt = `DLR_RST_DATA;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference routing per channel
  always @* begin
    for (i = 0; i < NCH; i = i + 1) begin
      ref_vdd_sel_nxt[i] = 1'b0;
      ref_bandgap_sel_nxt[i] = 1'b0;
      ref_pin_unbuf_sel_nxt[i] = 1'b0;
      ref_pin_buf_sel_nxt[i] = 1'b0;
      vref_pin_connect_nxt[i] = 1'b0;
      ref_buffer_gain2_nxt[i] = 1'b0;
      output_gain2_nxt[i] = output_gain_bit_r[i];
      case (reference_select_r[2*i+:2])
        `DLR_REF_VDD: begin
          // Supply fed internally, pin kept off the ladder, gain forced 1x
          ref_vdd_sel_nxt[i] = 1'b1;
          output_gain2_nxt[i] = 1'b0;
        end
        `DLR_REF_BANDGAP: begin
          ref_bandgap_sel_nxt[i] = 1'b1;
          ref_buffer_gain2_nxt[i] = 1'b1;
        end
        `DLR_REF_PIN_UNBUF: begin
          ref_pin_unbuf_sel_nxt[i] = 1'b1;
          vref_pin_connect_nxt[i] = 1'b1;
        end
        `DLR_REF_PIN_BUF: begin
          ref_pin_buf_sel_nxt[i] = 1'b1;
          vref_pin_connect_nxt[i] = 1'b1;
        end
        default: begin
          ref_vdd_sel_nxt[i] = 1'b1;
        end
      endcase
      // Reference switch opens in any power-down setting
      if (powerdown_select_r[2*i+:2] != 2'h0) begin
        ref_vdd_sel_nxt[i] = 1'b0;
        ref_bandgap_sel_nxt[i] = 1'b0;
        ref_pin_unbuf_sel_nxt[i] = 1'b0;
        ref_pin_buf_sel_nxt[i] = 1'b0;
        vref_pin_connect_nxt[i] = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State flip-flops
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_LOAD;
      value0_r <= `DLR_RST_VALUE;
      value1_r <= `DLR_RST_VALUE;
      reference_select_r <= `DLR_RST_VREF;
      powerdown_select_r <= `DLR_RST_PDOWN;
      output_gain_bit_r <= `DLR_RST_GAIN;
      channel_write_lock_r <= `DLR_RST_LOCK;
      reg_rdata_r <= `DLR_RST_DATA;
      reg_rvalid_r <= 1'b0;
      reg_wr_ignored_r <= 1'b0;
      ref_vdd_sel_r <= {NCH{1'b0}};
      ref_bandgap_sel_r <= {NCH{1'b0}};
      ref_pin_unbuf_sel_r <= {NCH{1'b0}};
      ref_pin_buf_sel_r <= {NCH{1'b0}};
      vref_pin_connect_r <= {NCH{1'b0}};
      ref_buffer_gain2_r <= {NCH{1'b0}};
      output_gain2_r <= {NCH{1'b0}};
    end else begin
      state_r <= state_nxt;
      value0_r <= value0_nxt;
      value1_r <= value1_nxt;
      reference_select_r <= reference_select_nxt;
      powerdown_select_r <= powerdown_select_nxt;
      output_gain_bit_r <= output_gain_bit_nxt;
      channel_write_lock_r <= channel_write_lock_nxt;
      reg_rdata_r <= reg_rd ? reg_rdata_nxt : `DLR_RST_DATA;
      reg_rvalid_r <= reg_rd && (state_r == ST_RUN);
      reg_wr_ignored_r <= reg_wr_ignored_nxt;
      ref_vdd_sel_r <= ref_vdd_sel_nxt;
      ref_bandgap_sel_r <= ref_bandgap_sel_nxt;
      ref_pin_unbuf_sel_r <= ref_pin_unbuf_sel_nxt;
      ref_pin_buf_sel_r <= ref_pin_buf_sel_nxt;
      vref_pin_connect_r <= vref_pin_connect_nxt;
      ref_buffer_gain2_r <= ref_buffer_gain2_nxt;
      output_gain2_r <= output_gain2_nxt;
    end
  end

endmodule

// ---- src/dlr_map.vh ----
/*
  Holds: register offsets, field positions and reset values of the
  DAC lock and reference selection slice.
  Assumes: included by bare name from the design files of this block.
*/
`ifndef DLR_MAP_VH
`define DLR_MAP_VH

// Geometry
`define DLR_CHANNELS 2
`define DLR_RES_BITS 12
`define DLR_DATA_BITS 16
`define DLR_ADDR_BITS 5

// Register offsets
`define DLR_OFS_VALUE0 5'h00
`define DLR_OFS_VALUE1 5'h01
`define DLR_OFS_VREF 5'h08
`define DLR_OFS_PDOWN 5'h09
`define DLR_OFS_GAIN 5'h0A
`define DLR_OFS_LOCK 5'h1B

// Field positions
`define DLR_LOCK_CFG_BIT 0
`define DLR_LOCK_VAL_BIT 1
`define DLR_GAIN_LSB 8

// Reference select encodings
`define DLR_REF_VDD 2'h0
`define DLR_REF_BANDGAP 2'h1
`define DLR_REF_PIN_UNBUF 2'h2
`define DLR_REF_PIN_BUF 2'h3

// Reset values
`define DLR_RST_VALUE 12'h000
`define DLR_RST_VREF 4'h0
`define DLR_RST_PDOWN 4'h0
`define DLR_RST_GAIN 2'h0
`define DLR_RST_LOCK 4'h0
`define DLR_RST_DATA 16'h0000

`endif

// ---- src/dlr_tap_decode.v ----
/*
  Holds: per-channel ladder tap decoder with power-down disconnect.
  Assumes: value and power-down select come from registers on the same clock.
*/
`timescale 1ns/1ps
`include "dlr_map.vh"

module dlr_tap_decode (
  // Clock and reset
  input wire clock,
  input wire nrst,
  // Channel controls
  input wire [`DLR_RES_BITS-1:0] value,
  input wire [1:0] powerdown_select,
  // Ladder controls
  output reg [`DLR_RES_BITS-1:0] tap_r,
  output reg connect_r
);

  reg [`DLR_RES_BITS-1:0] tap_nxt;
  reg connect_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Tap position equals the code; an n-bit code tops out at 2^n - 1
  always @* begin
    tap_nxt = value;
    connect_nxt = (powerdown_select == 2'h0);
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tap_r <= `DLR_RST_VALUE;
      connect_r <= 1'b0;
    end else begin
      tap_r <= tap_nxt;
      connect_r <= connect_nxt;
    end
  end

endmodule
